// >>> mpp_port_ctrl.v
// Port pin multiplexer: latches, direction, mode and pull-up control for
// ports 1 to 7, 12 and 13, with an Avalon-MM register slave and one interrupt.
// Assumes peripheral signals arrive on clk and pins are asynchronous.
//
// Implementation choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "mpp_defs.vh"
module mpp_port_ctrl #(
    parameter P6_OD_PULLUP = 0
) (
    input wire clk,
    input wire resetn,
    input wire [8:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    output reg irq,
    input wire [7:0] p1_in,
    output reg [7:0] p1_out,
    output reg [7:0] p1_oe,
    output reg [7:0] p1_pullup,
    input wire [7:0] p2_in,
    output reg [7:0] p2_out,
    output reg [7:0] p2_oe,
    output reg [7:0] p2_pullup,
    input wire [7:0] p3_in,
    output reg [7:0] p3_out,
    output reg [7:0] p3_oe,
    output reg [7:0] p3_pullup,
    input wire [7:0] p4_in,
    output reg [7:0] p4_out,
    output reg [7:0] p4_oe,
    output reg [7:0] p4_pullup,
    input wire [7:0] p5_in,
    output reg [7:0] p5_out,
    output reg [7:0] p5_oe,
    output reg [7:0] p5_pullup,
    input wire [7:0] p6_in,
    output reg [7:0] p6_out,
    output reg [7:0] p6_oe,
    output reg [7:0] p6_pullup,
    input wire [2:0] p7_in,
    output reg [2:0] p7_out,
    output reg [2:0] p7_oe,
    output reg [2:0] p7_pullup,
    input wire [7:0] p12_in,
    output reg [7:0] p12_out,
    output reg [7:0] p12_oe,
    output reg [7:0] p12_pullup,
    input wire [1:0] p13_in,
    output reg [1:0] p13_out,
    output reg [1:0] p13_oe,
    output reg [1:0] p13_pullup,
    input wire [7:0] p2_alt_out,
    input wire [7:0] p3_alt_out,
    input wire [2:0] p7_alt_out,
    input wire [7:0] low_addr_data_bus_out,
    input wire low_addr_data_bus_oe,
    output reg [7:0] low_addr_data_bus_in,
    input wire [7:0] upper_address_bus,
    input wire read_strobe_n,
    input wire write_strobe_n,
    input wire address_latch_strobe,
    output reg ext_wait,
    input wire [7:0] realtime_output_bits,
    input wire realtime_trigger,
    output reg [7:0] converter_analog_inputs,
    output reg dac_output_zero,
    output reg dac_output_one,
    output reg falling_edge_test_flag
);
    reg [7:0] latch [0:8];
    reg [7:0] dir [0:8];
    reg [7:0] mode [0:8];
    reg [7:0] low_pullup_option_reg;
    reg [1:0] high_pullup_option_reg;
    reg [2:0] memory_expansion_mode_reg;
    reg [0:0] status;
    reg [0:0] mask;
    reg [7:0] rtp_hold;
    reg [7:0] next_rtp_hold;
    reg [31:0] next_readdata;
    reg [7:0] n_out [0:8];
    reg [7:0] n_oe [0:8];
    reg [7:0] n_pu [0:8];
    wire [71:0] pins_raw;
    wire [71:0] pins_sync;
    wire [71:0] pins_prev;
    wire [7:0] p4_sync;
    wire [7:0] p4_prev;
    wire p4_fall;
    wire ext_on;
    wire wait_on;
    wire [2:0] grp;
    wire [3:0] idx;
    wire acc_done;
    integer i;

    // Pull-up applies only to port-mode inputs whose option bit is set.
    function [7:0] port_pull;
        input [7:0] d;
        input [7:0] m;
        input opt;
        begin
            port_pull = d & ~m & {8{opt}};
        end
    endfunction

    // Byte-lane merge of an 8-bit field from the write data.
    function [7:0] lane0;
        input [7:0] old;
        input [31:0] wd;
        input [3:0] be;
        begin
            lane0 = be[0] ? wd[7:0] : old;
        end
    endfunction

    assign pins_raw = {6'h00, p13_in, p12_in, 5'h00, p7_in, p6_in, p5_in,
                       p4_in, p3_in, p2_in, p1_in};
    mpp_sync #(
        .WIDTH(`MPP_PINS_W)
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .async_in(pins_raw),
        .sync_out(pins_sync),
        .sync_prev(pins_prev)
    );

    assign p4_sync = pins_sync[`MPP_IDX_P4*`MPP_PORT_W +: `MPP_PORT_W];
    assign p4_prev = pins_prev[`MPP_IDX_P4*`MPP_PORT_W +: `MPP_PORT_W];
    assign p4_fall = |(p4_prev & ~p4_sync);
    assign ext_on = memory_expansion_mode_reg[`MPP_MEMX_EXT_EN];
    assign wait_on = ext_on & memory_expansion_mode_reg[`MPP_MEMX_WAIT_EN];
    assign grp = avs_address[8:6];
    assign idx = avs_address[5:2];
    assign acc_done = (avs_read | avs_write) & ~avs_waitrequest;

    // Read data mux; unmapped offsets read as zero.
    always @* begin
        next_readdata = 32'h00000000;
        case (grp)
            `MPP_GRP_LATCH: begin
                if (idx < `MPP_NPORTS)
                    next_readdata[7:0] = latch[idx];
            end
            `MPP_GRP_DIR: begin
                if (idx < `MPP_NPORTS)
                    next_readdata[7:0] = dir[idx];
            end
            `MPP_GRP_MODE: begin
                if (idx < `MPP_NPORTS)
                    next_readdata[7:0] = mode[idx];
            end
            `MPP_GRP_PIN: begin
                if (idx < `MPP_NPORTS)
                    next_readdata[7:0] = pins_sync[idx*`MPP_PORT_W +: `MPP_PORT_W];
            end
            `MPP_GRP_MISC: begin
                case (idx)
                    `MPP_OFS_LOW_PULLUP: next_readdata[7:0] = low_pullup_option_reg;
                    `MPP_OFS_HIGH_PULLUP: next_readdata[1:0] = high_pullup_option_reg;
                    `MPP_OFS_MEMX: next_readdata[2:0] = memory_expansion_mode_reg;
                    `MPP_OFS_STATUS: next_readdata[0:0] = status;
                    `MPP_OFS_MASK: next_readdata[0:0] = mask;
                    default: next_readdata = 32'h00000000;
                endcase
            end
            default: next_readdata = 32'h00000000;
        endcase
    end

    // Every access answers one cycle after it appears and completes the next edge.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else if (acc_done) begin
            avs_waitrequest <= 1'b1;
        end else if (avs_read | avs_write) begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= next_readdata;
        end
    end

    // Register writes take effect only at the completing edge.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (i = 0; i < `MPP_NPORTS; i = i + 1) begin
                latch[i] <= `MPP_RST_LATCH;
                dir[i] <= `MPP_RST_DIR;
                mode[i] <= `MPP_RST_MODE;
            end
            low_pullup_option_reg <= `MPP_RST_OPT;
            high_pullup_option_reg <= 2'h0;
            memory_expansion_mode_reg <= `MPP_RST_MEMX;
            mask <= 1'h0;
        end else if (avs_write && !avs_waitrequest) begin
            case (grp)
                `MPP_GRP_LATCH: begin
                    if (idx < `MPP_NPORTS)
                        latch[idx] <= lane0(latch[idx], avs_writedata, avs_byteenable);
                end
                `MPP_GRP_DIR: begin
                    if (idx < `MPP_NPORTS)
                        dir[idx] <= lane0(dir[idx], avs_writedata, avs_byteenable);
                end
                `MPP_GRP_MODE: begin
                    if (idx < `MPP_NPORTS)
                        mode[idx] <= lane0(mode[idx], avs_writedata, avs_byteenable);
                end
                `MPP_GRP_MISC: begin
                    case (idx)
                        `MPP_OFS_LOW_PULLUP: low_pullup_option_reg <=
                            lane0(low_pullup_option_reg, avs_writedata, avs_byteenable);
                        `MPP_OFS_HIGH_PULLUP: begin
                            if (avs_byteenable[0])
                                high_pullup_option_reg <= avs_writedata[1:0];
                        end
                        `MPP_OFS_MEMX: begin
                            if (avs_byteenable[0])
                                memory_expansion_mode_reg <= avs_writedata[2:0];
                        end
                        `MPP_OFS_MASK: begin
                            if (avs_byteenable[0])
                                mask <= avs_writedata[0:0];
                        end
                        default: mask <= mask;
                    endcase
                end
                default: mask <= mask;
            endcase
        end
    end

    // Sticky falling-edge flag; a new edge wins over a write-one clear.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status <= 1'h0;
            irq <= 1'b0;
            falling_edge_test_flag <= 1'b0;
        end else begin
            if (p4_fall)
                status[`MPP_ST_FALL] <= 1'b1;
            else if (avs_write && !avs_waitrequest && grp == `MPP_GRP_MISC &&
                     idx == `MPP_OFS_STATUS && avs_byteenable[0] &&
                     avs_writedata[`MPP_ST_FALL])
                status[`MPP_ST_FALL] <= 1'b0;
            irq <= |(status & mask);
            falling_edge_test_flag <= status[`MPP_ST_FALL];
        end
    end

    // Real-time data is only taken on the trigger, so the pins move together.
    always @* begin
        next_rtp_hold = rtp_hold;
        if (realtime_trigger)
            next_rtp_hold = realtime_output_bits;
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn)
            rtp_hold <= 8'h00;
        else
            rtp_hold <= next_rtp_hold;
    end

    // Pin drive selection; direction bit one means input.
    always @* begin
        for (i = 0; i < `MPP_NPORTS; i = i + 1) begin
            n_out[i] = latch[i];
            n_oe[i] = ~dir[i];
            n_pu[i] = 8'h00;
        end
        // Port 1 alternate use is an analog input: no drive, no pull-up.
        n_oe[`MPP_IDX_P1] = ~dir[`MPP_IDX_P1] & ~mode[`MPP_IDX_P1];
        n_pu[`MPP_IDX_P1] = port_pull(dir[`MPP_IDX_P1], mode[`MPP_IDX_P1],
                                      low_pullup_option_reg[1]);
        // Serial pins keep the software direction; data comes from the peripheral.
        n_out[`MPP_IDX_P2] = (latch[`MPP_IDX_P2] & ~mode[`MPP_IDX_P2]) |
                             (p2_alt_out & mode[`MPP_IDX_P2]);
        n_pu[`MPP_IDX_P2] = port_pull(dir[`MPP_IDX_P2], mode[`MPP_IDX_P2],
                                      low_pullup_option_reg[2]);
        n_out[`MPP_IDX_P3] = (latch[`MPP_IDX_P3] & ~mode[`MPP_IDX_P3]) |
                             (p3_alt_out & mode[`MPP_IDX_P3]);
        n_pu[`MPP_IDX_P3] = port_pull(dir[`MPP_IDX_P3], mode[`MPP_IDX_P3],
                                      low_pullup_option_reg[3]);
        // Port 4 is steered as a whole byte by the expansion register.
        if (ext_on) begin
            n_out[`MPP_IDX_P4] = low_addr_data_bus_out;
            n_oe[`MPP_IDX_P4] = {8{low_addr_data_bus_oe}};
            n_pu[`MPP_IDX_P4] = 8'h00;
        end else begin
            n_oe[`MPP_IDX_P4] = {8{~memory_expansion_mode_reg[`MPP_MEMX_P4_IN]}};
            n_pu[`MPP_IDX_P4] = {8{memory_expansion_mode_reg[`MPP_MEMX_P4_IN] &
                                   low_pullup_option_reg[4]}};
        end
        if (ext_on) begin
            n_out[`MPP_IDX_P5] = upper_address_bus;
            n_oe[`MPP_IDX_P5] = 8'hFF;
        end else begin
            n_pu[`MPP_IDX_P5] = port_pull(dir[`MPP_IDX_P5], mode[`MPP_IDX_P5],
                                          low_pullup_option_reg[5]);
        end
        // Low half of port 6 only sinks current; high level comes from outside.
        n_out[`MPP_IDX_P6] = latch[`MPP_IDX_P6] & `MPP_P6_PU_MASK;
        n_oe[`MPP_IDX_P6] = ~dir[`MPP_IDX_P6] &
                            (`MPP_P6_PU_MASK | ~latch[`MPP_IDX_P6]);
        n_pu[`MPP_IDX_P6] = port_pull(dir[`MPP_IDX_P6], mode[`MPP_IDX_P6],
                                      low_pullup_option_reg[6]) & `MPP_P6_PU_MASK;
        if (P6_OD_PULLUP != 0)
            n_pu[`MPP_IDX_P6] = n_pu[`MPP_IDX_P6] | `MPP_P6_OD_MASK;
        if (ext_on) begin
            n_out[`MPP_IDX_P6][`MPP_P6_RD] = read_strobe_n;
            n_out[`MPP_IDX_P6][`MPP_P6_WR] = write_strobe_n;
            n_out[`MPP_IDX_P6][`MPP_P6_ADDRESS_LATCH_STROBE] = address_latch_strobe;
            n_oe[`MPP_IDX_P6][`MPP_P6_RD] = 1'b1;
            n_oe[`MPP_IDX_P6][`MPP_P6_WR] = 1'b1;
            n_oe[`MPP_IDX_P6][`MPP_P6_ADDRESS_LATCH_STROBE] = 1'b1;
            n_pu[`MPP_IDX_P6][`MPP_P6_RD] = 1'b0;
            n_pu[`MPP_IDX_P6][`MPP_P6_WR] = 1'b0;
            n_pu[`MPP_IDX_P6][`MPP_P6_ADDRESS_LATCH_STROBE] = 1'b0;
        end
        if (wait_on) begin
            n_oe[`MPP_IDX_P6][`MPP_P6_WAIT] = 1'b0;
            n_pu[`MPP_IDX_P6][`MPP_P6_WAIT] = 1'b0;
        end
        n_out[`MPP_IDX_P7] = (latch[`MPP_IDX_P7] & ~mode[`MPP_IDX_P7]) |
                             ({5'h00, p7_alt_out} & mode[`MPP_IDX_P7]);
        n_pu[`MPP_IDX_P7] = port_pull(dir[`MPP_IDX_P7], mode[`MPP_IDX_P7],
                                      low_pullup_option_reg[7]);
        n_out[`MPP_IDX_P12] = (latch[`MPP_IDX_P12] & ~mode[`MPP_IDX_P12]) |
                              (rtp_hold & mode[`MPP_IDX_P12]);
        n_oe[`MPP_IDX_P12] = ~dir[`MPP_IDX_P12] | mode[`MPP_IDX_P12];
        n_pu[`MPP_IDX_P12] = port_pull(dir[`MPP_IDX_P12], mode[`MPP_IDX_P12],
                                       high_pullup_option_reg[0]);
        // Analog outputs take the pin, so the digital driver lets go.
        n_oe[`MPP_IDX_P13] = ~dir[`MPP_IDX_P13] & ~mode[`MPP_IDX_P13];
        n_pu[`MPP_IDX_P13] = port_pull(dir[`MPP_IDX_P13], mode[`MPP_IDX_P13],
                                       high_pullup_option_reg[1]);
    end

    // All pin controls are registered so outputs come straight from flops.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            p1_out <= 8'h00; p1_oe <= 8'h00; p1_pullup <= 8'h00;
            p2_out <= 8'h00; p2_oe <= 8'h00; p2_pullup <= 8'h00;
            p3_out <= 8'h00; p3_oe <= 8'h00; p3_pullup <= 8'h00;
            p4_out <= 8'h00; p4_oe <= 8'h00; p4_pullup <= 8'h00;
            p5_out <= 8'h00; p5_oe <= 8'h00; p5_pullup <= 8'h00;
            p6_out <= 8'h00; p6_oe <= 8'h00; p6_pullup <= 8'h00;
            p7_out <= 3'h0; p7_oe <= 3'h0; p7_pullup <= 3'h0;
            p12_out <= 8'h00; p12_oe <= 8'h00; p12_pullup <= 8'h00;
            p13_out <= 2'h0; p13_oe <= 2'h0; p13_pullup <= 2'h0;
            low_addr_data_bus_in <= 8'h00;
            ext_wait <= 1'b0;
            converter_analog_inputs <= 8'h00;
            dac_output_zero <= 1'b0;
            dac_output_one <= 1'b0;
        end else begin
            p1_out <= n_out[`MPP_IDX_P1]; p1_oe <= n_oe[`MPP_IDX_P1];
            p1_pullup <= n_pu[`MPP_IDX_P1];
            p2_out <= n_out[`MPP_IDX_P2]; p2_oe <= n_oe[`MPP_IDX_P2];
            p2_pullup <= n_pu[`MPP_IDX_P2];
            p3_out <= n_out[`MPP_IDX_P3]; p3_oe <= n_oe[`MPP_IDX_P3];
            p3_pullup <= n_pu[`MPP_IDX_P3];
            p4_out <= n_out[`MPP_IDX_P4]; p4_oe <= n_oe[`MPP_IDX_P4];
            p4_pullup <= n_pu[`MPP_IDX_P4];
            p5_out <= n_out[`MPP_IDX_P5]; p5_oe <= n_oe[`MPP_IDX_P5];
            p5_pullup <= n_pu[`MPP_IDX_P5];
            p6_out <= n_out[`MPP_IDX_P6]; p6_oe <= n_oe[`MPP_IDX_P6];
            p6_pullup <= n_pu[`MPP_IDX_P6];
            p7_out <= n_out[`MPP_IDX_P7][2:0]; p7_oe <= n_oe[`MPP_IDX_P7][2:0];
            p7_pullup <= n_pu[`MPP_IDX_P7][2:0];
            p12_out <= n_out[`MPP_IDX_P12]; p12_oe <= n_oe[`MPP_IDX_P12];
            p12_pullup <= n_pu[`MPP_IDX_P12];
            p13_out <= n_out[`MPP_IDX_P13][1:0]; p13_oe <= n_oe[`MPP_IDX_P13][1:0];
            p13_pullup <= n_pu[`MPP_IDX_P13][1:0];
            low_addr_data_bus_in <= p4_sync;
            ext_wait <= wait_on & pins_sync[`MPP_IDX_P6*`MPP_PORT_W + `MPP_P6_WAIT];
            converter_analog_inputs <= mode[`MPP_IDX_P1];
            dac_output_zero <= mode[`MPP_IDX_P13][0];
            dac_output_one <= mode[`MPP_IDX_P13][1];
        end
    end
endmodule // mpp_port_ctrl
`default_nettype wire

// >>> mpp_defs.vh
// Constants for the multiplexed port pin controller: register byte offsets,
// reset values, field positions and port indices.
// Assumes a 32-bit Avalon-MM bus with byte addresses and a single 25 MHz clock.
// How it works
// - Ports 1, 2, 3, 7, 12 and 13 each have a mode register that picks port or alternate use per bit; the port 5 and 6 mode bits only gate the pull-up.
// - Each per-bit port has its own direction register in which a one makes that pin an input, except port 12 alternate pins and expansion bus pins.
// - Port 4 takes mode and direction for all eight pins at once from the memory expansion mode register.
// - Ports 1 to 5, port 7 and pins 4 to 7 of port 6 get a pull-up only as inputs with their low option bit set.
// - Ports 12 and 13 get a pull-up only as inputs with their high option bit set.
// - Port 1 pins used as converter analog inputs never have a pull-up.
// - In memory expansion mode port 4 carries the multiplexed low address and data bus with pull-ups off.
// - In memory expansion mode port 5 drives address bits 8 to 15 with pull-ups off.
// - In memory expansion mode port 6 carries read, write and address latch strobes, and wait when wait insertion is on, with pull-ups off.
// - With memory expansion on but wait insertion off, the wait pin stays an ordinary port pin.
// - A falling edge on any port 4 pin sets the test input flag.
// - Port 6 pins 0 to 3 are open-drain outputs whose pull-ups are only a fixed build option.
// - Port 7 has three bits, port 13 two bits and the other ports eight bits each.
// - In alternate mode port 12 outputs real-time data updated on a trigger.
`ifndef MPP_DEFS_VH
`define MPP_DEFS_VH

`define MPP_PORT_W 8
`define MPP_NPORTS 9
`define MPP_PINS_W 72
`define MPP_P7_W 3
`define MPP_P13_W 2

// Port indices in the register arrays.
`define MPP_IDX_P1 0
`define MPP_IDX_P2 1
`define MPP_IDX_P3 2
`define MPP_IDX_P4 3
`define MPP_IDX_P5 4
`define MPP_IDX_P6 5
`define MPP_IDX_P7 6
`define MPP_IDX_P12 7
`define MPP_IDX_P13 8

// Byte offsets; array groups hold one word per port index.
`define MPP_ADDR_W 9
`define MPP_GRP_LATCH 3'h0
`define MPP_GRP_DIR 3'h1
`define MPP_GRP_MODE 3'h2
`define MPP_GRP_PIN 3'h3
`define MPP_GRP_MISC 3'h4
`define MPP_OFS_LOW_PULLUP 4'h0
`define MPP_OFS_HIGH_PULLUP 4'h1
`define MPP_OFS_MEMX 4'h2
`define MPP_OFS_STATUS 4'h3
`define MPP_OFS_MASK 4'h4

// Reset values.
`define MPP_RST_LATCH 8'h00
`define MPP_RST_DIR 8'hFF
`define MPP_RST_MODE 8'h00
`define MPP_RST_OPT 8'h00
`define MPP_RST_MEMX 3'h4

// Memory expansion mode register fields.
`define MPP_MEMX_EXT_EN 0
`define MPP_MEMX_WAIT_EN 1
`define MPP_MEMX_P4_IN 2

// Status and mask fields.
`define MPP_ST_FALL 0

// Port 6 pin positions.
`define MPP_P6_RD 4
`define MPP_P6_WR 5
`define MPP_P6_WAIT 6
`define MPP_P6_ADDRESS_LATCH_STROBE 7
`define MPP_P6_OD_MASK 8'h0F
`define MPP_P6_PU_MASK 8'hF0

`endif

// >>> mpp_sync.v
// Two-stage synchroniser for the port pin inputs, with a third stage kept
// for edge detection. Assumes pins are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module mpp_sync #(
    parameter WIDTH = 8
) (
    input wire clk,
    input wire resetn,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out,
    output reg [WIDTH-1:0] sync_prev
);
    reg [WIDTH-1:0] meta;

    // The first stage feeds only the second; edge logic uses the later stages.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta <= {WIDTH{1'b1}};
            sync_out <= {WIDTH{1'b1}};
            sync_prev <= {WIDTH{1'b1}};
        end else begin
            meta <= async_in;
            sync_out <= meta;
            sync_prev <= sync_out;
        end
    end
endmodule // mpp_sync
`default_nettype wire

// >>> mpp_pin_board.sv
// Board model: each pin follows the port drive, else the pull-up, else the board.
// Assumes the board drive is always defined; a floating pin is not modelled.
`timescale 1ns/1ps
`default_nettype none
module mpp_pin_board #(
    parameter int W = 8
) (
    input wire logic [W-1:0] drv,
    input wire logic [W-1:0] oe,
    input wire logic [W-1:0] pu,
    input wire logic [W-1:0] ext,
    output logic [W-1:0] pin
);
    // A strong external drive is not modelled, so the board only acts on released pins.
    assign pin = (oe & drv) | (~oe & pu) | (~oe & ~pu & ext);
endmodule // mpp_pin_board
`default_nettype wire

// >>> mpp_port_checker.sv
// Checker for the port pin controller, built on its top-level ports only.
// Assumes it is bound to mpp_port_ctrl and shares its single clock.
`timescale 1ns/1ps
`default_nettype none
module mpp_port_checker (
    input wire logic clk,
    input wire logic resetn,
    input wire logic avs_waitrequest,
    input wire logic irq,
    input wire logic falling_edge_test_flag,
    input wire logic [7:0] p1_oe,
    input wire logic [7:0] p1_pullup,
    input wire logic [7:0] converter_analog_inputs,
    input wire logic [7:0] p4_in,
    input wire logic [7:0] p4_oe,
    input wire logic [7:0] p6_out,
    input wire logic [7:0] p6_oe,
    input wire logic [7:0] p12_oe,
    input wire logic [7:0] p12_pullup,
    input wire logic [1:0] p13_oe,
    input wire logic [1:0] p13_pullup
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // The pin must stay low long enough to pass the synchroniser.
    sequence s_fall;
        (|($past(p4_in) & ~p4_in)) ##1 $stable(p4_in) [*3];
    endsequence
    a_fall_sets_flag: assert property (s_fall |-> ##[0:3] falling_edge_test_flag)
        else $error("falling edge missed");
    a_irq_needs_flag: assert property (!falling_edge_test_flag |-> !irq)
        else $error("irq without flag");
    a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_p1_pullup_input: assert property ((p1_pullup & (p1_oe | converter_analog_inputs)) == 8'h00)
        else $error("port 1 pull-up misuse");
    a_p12_pullup_input: assert property ((p12_pullup & p12_oe) == 8'h00)
        else $error("port 12 pull-up misuse");
    a_p13_pullup_input: assert property ((p13_pullup & p13_oe) == 2'h0)
        else $error("port 13 pull-up misuse");
    a_p4_oe_group: assert property (p4_oe == 8'h00 || p4_oe == 8'hFF)
        else $error("port 4 direction split");
    a_p6_open_drain: assert property ((p6_out[3:0] & p6_oe[3:0]) == 4'h0)
        else $error("port 6 drives high");
    a_reset_inputs: assert property ($rose(resetn) |-> (p1_oe | p4_oe | p1_pullup) == 8'h00)
        else $error("pins not inputs after reset");
endmodule // mpp_port_checker
bind mpp_port_ctrl mpp_port_checker chk_i (.*);
`default_nettype wire

// >>> tb_mpp_port_ctrl.sv
// Bench for mpp_port_ctrl: register traffic, pin checks and a board model.
// Assumes the register map and latencies of the designer's note.
`timescale 1ns/1ps
`default_nettype none
module tb_mpp_port_ctrl;
    logic clk, resetn, avs_read, avs_write, avs_waitrequest, irq, low_addr_data_bus_oe;
    logic read_strobe_n, write_strobe_n, address_latch_strobe, ext_wait, realtime_trigger;
    logic dac_output_zero, dac_output_one, falling_edge_test_flag;
    logic [8:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd, seed;
    logic [3:0] avs_byteenable;
    logic [7:0] p1_in, p1_out, p1_oe, p1_pullup, p2_in, p2_out, p2_oe, p2_pullup, p3_in;
    logic [7:0] p3_out, p3_oe, p3_pullup, p4_in, p4_out, p4_oe, p4_pullup, p5_in, p5_out;
    logic [7:0] p5_oe, p5_pullup, p6_in, p6_out, p6_oe, p6_pullup, p12_in, p12_out, p12_oe;
    logic [7:0] p12_pullup, p2_alt_out, p3_alt_out, low_addr_data_bus_out, low_addr_data_bus_in;
    logic [7:0] upper_address_bus, realtime_output_bits, converter_analog_inputs, x1, x4, d, l, m;
    logic [2:0] p7_in, p7_out, p7_oe, p7_pullup, p7_alt_out;
    logic [1:0] p13_in, p13_out, p13_oe, p13_pullup;
    int error_cnt, tests_run, n;
    mpp_port_ctrl dut (.*);
    mpp_pin_board b1 (.drv(p1_out), .oe(p1_oe), .pu(p1_pullup), .ext(x1), .pin(p1_in));
    mpp_pin_board b4 (.drv(p4_out), .oe(p4_oe), .pu(p4_pullup), .ext(x4), .pin(p4_in));
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function logic [7:0] pin1(input logic [7:0] dd, ll, mm, xx);
        return (~dd & ~mm & ll) | (dd & ~mm) | (mm & xx);
    endfunction
    task automatic summarize();
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [8:0] a, input logic [7:0] v);
        int k;
        k = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= {24'h0, v};
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (k >= 50) begin
            chk(k, 0);
            summarize();
        end
    endtask
    // Three edges cover the pin update and the two synchroniser stages; the register write lands on the last edge of bus.
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        seed = 32'h9213;
        error_cnt = 0;
        tests_run = 0;
        {resetn, avs_read, avs_write, avs_address, avs_writedata, x4} = {12'h0, 32'h0, 8'hFF};
        avs_byteenable = 4'h1;
        {p2_in, p3_in, p5_in, p6_in} = rnd();
        {p12_in, p2_alt_out, p3_alt_out, p13_in, p7_alt_out, p7_in} = rnd();
        {low_addr_data_bus_out, upper_address_bus, realtime_output_bits, x1} = rnd();
        {low_addr_data_bus_oe, read_strobe_n, write_strobe_n, address_latch_strobe} = 4'h0;
        realtime_trigger = 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        settle();
        chk({p1_oe, p4_oe, p1_pullup, p12_pullup}, 32'h0);
        bus(0, 9'h040, 8'h00);
        chk(rd, 32'hFF);
        bus(0, 9'h1FC, 8'h00);
        chk(rd, 32'h0);
        bus(1, 9'h100, 8'hFE);
        repeat (6) begin
            rd = rnd();
            {d, l, m} = rd[23:0];
            @(posedge clk);
            x1 <= rd[31:24];
            bus(1, 9'h000, l);
            bus(1, 9'h040, d);
            bus(1, 9'h080, m);
            settle();
            chk(p1_oe, 8'(~d & ~m));
            chk({p1_pullup, converter_analog_inputs}, {8'(d & ~m), m});
            chk(p1_out & p1_oe, 8'(l & ~d & ~m));
            bus(0, 9'h0C0, 8'h00);
            chk(rd, pin1(d, l, m, x1));
        end
        bus(1, 9'h104, 8'h03);
        settle();
        chk({p12_pullup, p13_pullup}, 10'h3FF);
        @(posedge clk);
        realtime_trigger <= 1'b1;
        @(posedge clk);
        realtime_trigger <= 1'b0;
        bus(1, 9'h09C, 8'hFF);
        bus(1, 9'h0A0, 8'h03);
        settle();
        chk(p12_out, realtime_output_bits);
        chk({p12_pullup, p13_pullup, dac_output_one, dac_output_zero}, 12'h3);
        bus(1, 9'h084, 8'hF0);
        bus(1, 9'h044, 8'h0F);
        bus(1, 9'h0A0, 8'h01);
        bus(1, 9'h060, 8'h01);
        settle();
        chk({p2_out, p2_oe, p13_out, p13_oe}, {p2_alt_out[7:4], 12'h0F0, 4'h2});
        bus(1, 9'h108, 8'h00);
        settle();
        chk({p4_oe, p4_pullup}, 16'hFF00);
        bus(1, 9'h108, 8'h04);
        settle();
        chk({p4_oe, p4_pullup}, 16'h00FF);
        @(posedge clk);
        {low_addr_data_bus_oe, read_strobe_n, write_strobe_n, address_latch_strobe} <= 4'hD;
        bus(1, 9'h108, 8'h01);
        settle();
        chk(p4_out, low_addr_data_bus_out);
        chk({p4_oe, p5_oe, p4_pullup, p5_pullup}, 32'hFFFF0000);
        chk({p5_out, p6_out[7], p6_out[5:4]}, {upper_address_bus, 3'h5});
        chk({p6_pullup[7:4], ext_wait}, 5'h08);
        bus(1, 9'h00C, 8'hFF);
        bus(1, 9'h108, 8'h00);
        bus(1, 9'h014, 8'h00);
        bus(1, 9'h054, 8'h00);
        settle();
        chk({p6_oe[3:0], p6_out[3:0]}, 8'hF0);
        bus(1, 9'h10C, 8'h01);
        bus(1, 9'h110, 8'h01);
        settle();
        chk({irq, falling_edge_test_flag}, 2'h0);
        bus(1, 9'h00C, 8'h7F);
        for (n = 0; n < 20 && irq !== 1'b1; n++) @(posedge clk);
        chk({irq, falling_edge_test_flag}, 2'h3);
        bus(1, 9'h10C, 8'h01);
        settle();
        chk({irq, falling_edge_test_flag}, 2'h0);
        summarize();
    end
endmodule // tb_mpp_port_ctrl
`default_nettype wire
